// file: chg_i2c_host.sv
`timescale 1ns/10ps
// --------------------------------------------
// Host bus master model, data wire pulled up
// --------------------------------------------
module chg_i2c_host (
    input wire logic clk_i, // Bench clock
    input wire logic sda_i, // Resolved data wire
    output logic scl_o,     // Bus clock, idle high
    output logic sda_o      // Low pulls data, high releases
);
    // Idle bus until the first start
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Quarter bit of four cycles, so the unsynchronised sampler sees every level
    task automatic step(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
        repeat (4) @(negedge clk_i);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        step(scl_o, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // Stop: data rises while clock is high
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Nine slots MSB first; data moves only while clock is low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, tx[i]);
            step(1'b1, tx[i]);
            rx[i] = sda_i;
            step(1'b1, tx[i]);
            step(1'b0, tx[i]);
        end
    endtask
endmodule

// file: chg_pkg.sv
package chg_pkg;

    // ------------------------------------------------------------
    // Register offsets (I2C subaddresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FUNC_ONE = 8'h07;
    localparam logic [7:0] ADDR_FUNC_TWO = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h09;
    localparam logic [7:0] ADDR_IRQ_PEND = 8'h0A;
    localparam logic [7:0] ADDR_STAT_ONE = 8'h0B;
    localparam logic [7:0] ADDR_STAT_TWO = 8'h0C;
    localparam logic [7:0] ADDR_FAULT = 8'h0D;
    localparam logic [7:0] ADDR_SHORT_CFG = 8'h10;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] FUNC_ONE_RST = 8'h47;
    localparam logic [7:0] FUNC_TWO_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] SHORT_CFG_RST = 8'h84;
    localparam int FC1_RUN_BIT = 0;
    localparam int FC1_TRICKLE_BIT = 1;
    localparam int FC1_EOC_BIT = 2;
    localparam int IRQ_VIN_BIT = 0;
    localparam int IRQ_CHG_BIT = 1;
    localparam int IRQ_BAT_BIT = 2;
    localparam int IRQ_THR_BIT = 3;
    localparam int IRQ_OT_BIT = 4;
    localparam int IRQ_WD_BIT = 5;
    localparam int IRQ_ISO_BIT = 6;
    localparam int IRQ_IPK_BIT = 7;
    localparam int FLT_OT_HIGH_BIT = 0;
    localparam int FLT_OT_LOW_BIT = 1;
    localparam int FLT_IPK_BIT = 2;
    localparam int FLT_SHORT_BIT = 3;
    localparam int SHORT_TMO_LSB = 5;
    localparam int SHORT_VOLT_LSB = 0;
    localparam logic [2:0] IPK_REPEAT_LIMIT = 3'h4;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200000000;
    localparam int TICK_RATE_HZ = 1000;
    localparam int TICK_CYC_DEF = CLK_HZ / TICK_RATE_HZ;
    localparam int MS_PER_S = 1000;
    localparam int WD_GRACE_SHORT_S = 2;
    localparam int WD_GRACE_LONG_S = 4;
    localparam int MS_W = 18;
    localparam int SHORT_TMO_S [8] = '{1, 2, 4, 10, 30, 60, 120, 180};

    // ------------------------------------------------------------
    // Encodings and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CHG_OFF = 3'b000, CHG_TRICKLE = 3'b001, CHG_FAST_CC = 3'b010,
        CHG_FAST_CV = 3'b011, CHG_COMPLETE = 3'b100, CHG_SUSPEND = 3'b101,
        CHG_TIMER_EXP = 3'b110, CHG_BAT_DETECT = 3'b111
    } chg_state_type;

    typedef enum logic [2:0] {
        BAT_MON_OFF = 3'b000, BAT_NONE = 3'b001, BAT_BELOW_TRK = 3'b010,
        BAT_TRK_TO_WEAK = 3'b011, BAT_ABOVE_WEAK = 3'b100
    } chg_bat_state_type;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000, I2C_ADDR = 3'b001, I2C_SUB = 3'b010, I2C_WDATA = 3'b011,
        I2C_RDATA = 3'b100, I2C_ACK_TX = 3'b101, I2C_ACK_RX = 3'b110
    } chg_i2c_state_type;

    typedef struct packed {
        logic input_overvoltage;
        logic input_good;
        logic input_current_limited;
        logic die_temp_limited;
        chg_state_type charger_state_code;
        logic [2:0] thermistor_state_code;
        chg_bat_state_type battery_state_code;
    } chg_sense_type;

    typedef struct packed {
        logic isothermal;
        logic thermistor;
        logic battery_level;
        logic charge_mode;
        logic input_level;
    } chg_event_type;

    typedef struct packed {
        logic converter_enable;
        logic trickle_path_enable;
        logic termination_permit;
        logic [2:0] short_voltage_sel;
        logic [7:0] func_one;
        logic [7:0] func_two;
    } chg_ctrl_type;

endpackage

// file: chg_regs.sv
`timescale 1ns/10ps
// Overview of operation
// RL1 - End of charge allowed only with permit bit
// RL2 - Trickle permit low disables trickle, runs converter
// RL3 - Run bit low disables the switching converter
// RL4 - Eight interrupt enables, reset zero, gate interrupts
// RL5 - Pending register flags source in enable position
// RL6 - Watchdog alarm within 2/4 sec of expiry
// RL7 - Status one reports overvoltage and input good
// RL8 - Status bit 5 shows input current limiting
// RL9 - Status bit 4 shows die temperature limiting
// RL10 - Charge done latches until power removal
// RL11 - Charger state field uses eight encodings
// RL12 - Peak repeat bit after four consecutive limits
// RL13 - Battery state field uses five encodings
// RL14 - Fault bit 3 on battery short
// RL15 - Fault bit 2 on inductor peak fault
// RL16 - Fault bits 1/0 on 130/140 degree faults
// RL17 - Fault bits clear by write one or power
// RL18 - Short timeout selected from eight durations
// RL19 - Short voltage threshold code, reset 100
// RL20 - Reads auto-increment subaddress until stop
// RL21 - Resume after shutdown needs cool die, cleared fault
// RL22 - Pending set with enable, cleared by reading
module chg_regs
    import chg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
    parameter int TICK_CYC = TICK_CYC_DEF   // Cycles per 1 ms tick
) (
    input wire logic core_clk_i,              // System clock
    input wire logic rst_n_i,                 // Sync reset, active low
    input wire logic scl_i,                   // I2C clock
    input wire logic sda_i,                   // I2C data in
    output logic sda_o,                       // I2C data out, always low
    output logic sda_oe_o,                    // High while pulling data low
    input wire chg_sense_type sense_i,        // Analog status levels
    input wire chg_event_type irq_evt_i,      // Interrupt source pulses
    input wire logic ipk_evt_i,               // Inductor peak limit pulse
    input wire logic ipk_clean_i,             // Cycle without peak limit
    input wire logic ot_low_evt_i,            // 130 C fault pulse
    input wire logic ot_high_evt_i,           // 140 C fault pulse
    input wire logic die_below_110_i,         // Die cooled below 110 C
    input wire logic charge_end_evt_i,        // End of charge cycle pulse
    input wire logic vin_lost_i,              // Input power removed
    input wire logic short_cmp_i,             // Battery below short threshold
    input wire logic watchdog_expired_i,      // Watchdog period elapsed
    input wire logic watchdog_period_sel_i,   // 0: 32 s period, 1: 64 s
    output chg_ctrl_type ctrl_o,              // Converter controls
    output logic [7:0] irq_pending_o          // Pending flags
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [MS_W-1:0] TICK_LAST = MS_W'(TICK_CYC - 1);
    localparam logic [MS_W-1:0] WD_SHORT_MS = MS_W'(WD_GRACE_SHORT_S * MS_PER_S);
    localparam logic [MS_W-1:0] WD_LONG_MS = MS_W'(WD_GRACE_LONG_S * MS_PER_S);

    chg_i2c_state_type state_q;
    logic scl_q, sda_q, drive_q, rd_mode_q, got_sub_q, mack_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q, tx_q, sub_q, rd_data;
    logic scl_rise, scl_fall, start_det, stop_det, wr_stb, rd_stb;
    logic [7:0] func_one_q, func_two_q, ien_q, pend_q, short_cfg_q, irq_src;
    logic [3:0] fault_q, fault_set, fault_w1c;
    logic [2:0] ipk_cnt_q;
    logic done_q, shutdown_q, wd_alarm, wd_armed_q, tick;
    logic [MS_W-1:0] tick_cnt_q, wd_ms_q, short_ms_q, short_limit, wd_limit;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // I2C slave
    // ------------------------------------------------------------
    // Pins are synchronous, so one delay stage gives the edges
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det = scl_i & scl_q & ~sda_q & sda_i;
    // Strobes fire on the SCL fall that closes a byte or an ack
    assign wr_stb = scl_fall && state_q == I2C_WDATA && cnt_q == I2C_BYTE_BITS;
    assign rd_stb = scl_fall && ((state_q == I2C_ACK_TX && rd_mode_q) ||
                                 (state_q == I2C_ACK_RX && mack_q));
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_q;

    // Byte engine; data changes only while SCL is low
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= I2C_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            sub_q <= 8'h00;
            drive_q <= 1'b0;
            rd_mode_q <= 1'b0;
            got_sub_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (start_det) begin
            state_q <= I2C_ADDR;
            cnt_q <= 4'h0;
            drive_q <= 1'b0;
            got_sub_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= I2C_IDLE;
            drive_q <= 1'b0;
        end else if (scl_rise) begin
            case (state_q)
                I2C_ADDR, I2C_SUB, I2C_WDATA: begin
                    shreg_q <= {shreg_q[6:0], sda_i};
                    cnt_q <= cnt_q + 4'h1;
                end
                I2C_RDATA: cnt_q <= cnt_q + 4'h1;
                I2C_ACK_RX: mack_q <= ~sda_i;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_q)
                I2C_ADDR: begin
                    if (cnt_q == I2C_BYTE_BITS) begin
                        if (shreg_q[7:1] == DEV_ADDR) begin
                            drive_q <= 1'b1;
                            rd_mode_q <= shreg_q[0];
                            state_q <= I2C_ACK_TX;
                        end else begin
                            state_q <= I2C_IDLE;
                        end
                    end
                end
                I2C_SUB: begin
                    if (cnt_q == I2C_BYTE_BITS) begin
                        sub_q <= shreg_q;
                        got_sub_q <= 1'b1;
                        drive_q <= 1'b1;
                        state_q <= I2C_ACK_TX;
                    end
                end
                I2C_WDATA: begin
                    if (cnt_q == I2C_BYTE_BITS) begin
                        sub_q <= sub_q + 8'h01;
                        drive_q <= 1'b1;
                        state_q <= I2C_ACK_TX;
                    end
                end
                I2C_ACK_TX, I2C_ACK_RX: begin
                    cnt_q <= 4'h0;
                    if (rd_stb) begin
                        // Load next byte and step the subaddress
                        tx_q <= rd_data; // RL20
                        drive_q <= ~rd_data[7];
                        sub_q <= sub_q + 8'h01; // RL20
                        state_q <= I2C_RDATA;
                    end else begin
                        drive_q <= 1'b0;
                        if (state_q == I2C_ACK_RX) begin
                            state_q <= I2C_IDLE;
                        end else if (got_sub_q) begin
                            state_q <= I2C_WDATA;
                        end else begin
                            state_q <= I2C_SUB;
                        end
                    end
                end
                I2C_RDATA: begin
                    if (cnt_q == I2C_BYTE_BITS) begin
                        drive_q <= 1'b0;
                        state_q <= I2C_ACK_RX;
                    end else begin
                        drive_q <= ~tx_q[3'(4'h7 - cnt_q)];
                    end
                end
                default: ;
            endcase
        end
    end

    a_read_autoinc: assert property (rd_stb |=> sub_q == $past(sub_q) + 8'h01) // RL20
        else $error("subaddress did not step on read");

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped subaddresses read as zero
    always_comb begin
        if (sub_q == ADDR_FUNC_ONE) begin
            rd_data = func_one_q;
        end else if (sub_q == ADDR_FUNC_TWO) begin
            rd_data = func_two_q;
        end else if (sub_q == ADDR_IRQ_EN) begin
            rd_data = ien_q;
        end else if (sub_q == ADDR_IRQ_PEND) begin
            rd_data = pend_q;
        end else if (sub_q == ADDR_STAT_ONE) begin
            rd_data = {sense_i.input_overvoltage, sense_i.input_good, // RL7
                       sense_i.input_current_limited, sense_i.die_temp_limited, // RL8 RL9
                       done_q, sense_i.charger_state_code}; // RL10 RL11
        end else if (sub_q == ADDR_STAT_TWO) begin
            rd_data = {sense_i.thermistor_state_code, ipk_cnt_q >= IPK_REPEAT_LIMIT,
                       1'b0, sense_i.battery_state_code}; // RL12 RL13
        end else if (sub_q == ADDR_FAULT) begin
            rd_data = {4'h0, fault_q};
        end else if (sub_q == ADDR_SHORT_CFG) begin
            rd_data = short_cfg_q;
        end else begin
            rd_data = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            func_one_q <= FUNC_ONE_RST;
            func_two_q <= FUNC_TWO_RST;
            ien_q <= IRQ_EN_RST; // RL4
            short_cfg_q <= SHORT_CFG_RST; // RL18 RL19
        end else if (wr_stb) begin
            if (sub_q == ADDR_FUNC_ONE) begin
                func_one_q <= shreg_q;
            end else if (sub_q == ADDR_FUNC_TWO) begin
                func_two_q <= shreg_q;
            end else if (sub_q == ADDR_IRQ_EN) begin
                ien_q <= shreg_q;
            end else if (sub_q == ADDR_SHORT_CFG) begin
                short_cfg_q <= shreg_q;
            end
        end
    end

    // Converter steering; thermal shutdown overrides the run bit
    always_comb begin
        ctrl_o.converter_enable = func_one_q[FC1_RUN_BIT] & ~shutdown_q; // RL3 RL21
        ctrl_o.trickle_path_enable = ctrl_o.converter_enable &
                                     func_one_q[FC1_TRICKLE_BIT]; // RL2
        ctrl_o.termination_permit = func_one_q[FC1_EOC_BIT]; // RL1
        ctrl_o.short_voltage_sel = short_cfg_q[SHORT_VOLT_LSB +: 3]; // RL19
        ctrl_o.func_one = func_one_q;
        ctrl_o.func_two = func_two_q;
    end

    a_eoc_permit: assert property (wr_stb && sub_q == ADDR_FUNC_ONE && !shreg_q[FC1_EOC_BIT]
        |=> !ctrl_o.termination_permit [*2]) // RL1
        else $error("termination permitted after clearing permit");
    a_trickle_off: assert property (wr_stb && sub_q == ADDR_FUNC_ONE &&
        !shreg_q[FC1_TRICKLE_BIT] |=> !ctrl_o.trickle_path_enable) // RL2
        else $error("trickle path left on");
    a_conv_off: assert property (wr_stb && sub_q == ADDR_FUNC_ONE && !shreg_q[FC1_RUN_BIT]
        |=> !ctrl_o.converter_enable) // RL3
        else $error("converter still running");

    // ------------------------------------------------------------
    // Millisecond tick, watchdog alarm, short detect
    // ------------------------------------------------------------
    // Long timeouts run on a 1 ms enable so counters stay narrow
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = tick_cnt_q == TICK_LAST;

    assign wd_limit = watchdog_period_sel_i ? WD_LONG_MS : WD_SHORT_MS; // RL6
    assign wd_alarm = wd_armed_q && tick && wd_ms_q == wd_limit - 1'b1;

    // Grace counter; alarm fires once per expiry
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !watchdog_expired_i) begin
            wd_ms_q <= '0;
            wd_armed_q <= 1'b1;
        end else if (tick && wd_armed_q) begin
            wd_ms_q <= wd_ms_q + 1'b1; // RL6
            wd_armed_q <= !wd_alarm;
        end
    end

    // Timeout table lookup by selected code
    always_comb begin
        short_limit = MS_W'(SHORT_TMO_S[short_cfg_q[SHORT_TMO_LSB +: 3]] * MS_PER_S); // RL18
    end

    // Counts how long the battery stays under the short threshold
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !short_cmp_i) begin
            short_ms_q <= '0;
        end else if (tick && short_ms_q != short_limit) begin
            short_ms_q <= short_ms_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Fault register, peak repeat, charge done, shutdown
    // ------------------------------------------------------------
    // Consecutive peak limits saturate at the repeat limit
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || ipk_clean_i) begin
            ipk_cnt_q <= 3'h0;
        end else if (ipk_evt_i && ipk_cnt_q != IPK_REPEAT_LIMIT) begin
            ipk_cnt_q <= ipk_cnt_q + 3'h1; // RL12
        end
    end

    always_comb begin
        fault_set = 4'h0;
        fault_set[FLT_SHORT_BIT] = short_cmp_i && tick &&
                                   short_ms_q == short_limit - 1'b1; // RL14
        fault_set[FLT_IPK_BIT] = ipk_evt_i && !ipk_clean_i &&
                                 ipk_cnt_q == IPK_REPEAT_LIMIT - 3'h1; // RL15
        fault_set[FLT_OT_LOW_BIT] = ot_low_evt_i; // RL16
        fault_set[FLT_OT_HIGH_BIT] = ot_high_evt_i; // RL16
        fault_w1c = (wr_stb && sub_q == ADDR_FAULT) ? shreg_q[3:0] : 4'h0;
    end

    // Write one or power loss clears; a new fault in the same cycle wins
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            fault_q <= 4'h0;
        end else begin
            fault_q <= (fault_q & ~fault_w1c & {4{~vin_lost_i}}) | fault_set; // RL17
        end
    end

    // Done stays latched through recharge; only power loss clears it
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
        end else if (charge_end_evt_i) begin
            done_q <= 1'b1; // RL10
        end else if (vin_lost_i) begin
            done_q <= 1'b0;
        end
    end

    // Shutdown holds until the die is cool and the fault bit is cleared
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            shutdown_q <= 1'b0;
        end else if (ot_high_evt_i) begin
            shutdown_q <= 1'b1;
        end else if (die_below_110_i && !fault_q[FLT_OT_HIGH_BIT]) begin
            shutdown_q <= 1'b0; // RL21
        end
    end

    sequence s_fourth_peak;
        ipk_evt_i && !ipk_clean_i && ipk_cnt_q == IPK_REPEAT_LIMIT - 3'h1;
    endsequence
    a_peak_repeat: assert property (s_fourth_peak |=> ipk_cnt_q == IPK_REPEAT_LIMIT
        && fault_q[FLT_IPK_BIT]) // RL12
        else $error("peak repeat not flagged");
    a_short_fault: assert property (short_cmp_i && tick && short_ms_q == short_limit - 1'b1
        |=> fault_q[FLT_SHORT_BIT]) // RL14
        else $error("battery short fault not set");
    a_fault_w1c: assert property (fault_w1c[FLT_OT_HIGH_BIT] && !ot_high_evt_i
        |=> !fault_q[FLT_OT_HIGH_BIT]) // RL17
        else $error("fault bit not cleared by write");
    a_done_holds: assert property (done_q && !vin_lost_i |=> done_q) // RL10
        else $error("charge done dropped");
    sequence s_hot_trip;
        ot_high_evt_i ##1 !die_below_110_i;
    endsequence
    a_shutdown_hold: assert property (s_hot_trip |-> !ctrl_o.converter_enable) // RL21
        else $error("converter resumed while hot");

    // ------------------------------------------------------------
    // Interrupt pending flags
    // ------------------------------------------------------------
    always_comb begin
        irq_src = 8'h00;
        irq_src[IRQ_VIN_BIT] = irq_evt_i.input_level;
        irq_src[IRQ_CHG_BIT] = irq_evt_i.charge_mode;
        irq_src[IRQ_BAT_BIT] = irq_evt_i.battery_level;
        irq_src[IRQ_THR_BIT] = irq_evt_i.thermistor;
        irq_src[IRQ_OT_BIT] = ot_low_evt_i | ot_high_evt_i;
        irq_src[IRQ_WD_BIT] = wd_alarm; // RL6
        irq_src[IRQ_ISO_BIT] = irq_evt_i.isothermal;
        irq_src[IRQ_IPK_BIT] = ipk_evt_i;
    end

    // Reading the register clears it; an event in that cycle survives
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pend_q <= 8'h00;
        end else begin
            pend_q <= (pend_q & ~{8{rd_stb && sub_q == ADDR_IRQ_PEND}})
                      | (irq_src & ien_q); // RL4 RL5 RL22
        end
    end
    assign irq_pending_o = pend_q;

    a_pend_needs_en: assert property (!(|(pend_q & ~$past(pend_q) & ~$past(ien_q)))) // RL4
        else $error("pending flag set without enable");
    a_pend_read_clr: assert property (rd_stb && sub_q == ADDR_IRQ_PEND && irq_src == 8'h00
        |=> pend_q == 8'h00) // RL22
        else $error("pending flags survived read");
    a_wd_pending: assert property (wd_alarm && ien_q[IRQ_WD_BIT] |=> pend_q[IRQ_WD_BIT]) // RL6
        else $error("watchdog alarm not flagged");

endmodule

// file: tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, s); end end
// --------------------------------------------
// Register bank bench
// --------------------------------------------
module tb_top;
    import chg_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;
    logic core_clk_i, rst_n_i, scl, h_sda, sda_o, sda_oe, ipk, clean, otl, oth, cool;
    logic cend, vlost, shrt, wdx, wsel;
    chg_sense_type sense;
    chg_event_type evt;
    chg_ctrl_type ctrl;
    logic [7:0] pend, rd_v, ex, m;
    logic [8:0] r;
    logic [7:0] q[$];
    int num_errors = 0, comparisons = 0, seed = 59;
    event got;
    wire sda_w = h_sda & ~(sda_oe & ~sda_o); // Open drain with pull-up
    chg_i2c_host h_u (.clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(h_sda));
    chg_regs #(.TICK_CYC(4)) dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .sense_i(sense), .irq_evt_i(evt),
        .ipk_evt_i(ipk), .ipk_clean_i(clean), .ot_low_evt_i(otl), .ot_high_evt_i(oth),
        .die_below_110_i(cool), .charge_end_evt_i(cend), .vin_lost_i(vlost),
        .short_cmp_i(shrt), .watchdog_expired_i(wdx), .watchdog_period_sel_i(wsel),
        .ctrl_o(ctrl), .irq_pending_o(pend));
    // 200 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Write one register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h_u.start();
        h_u.xfer({DEV, 1'b0, 1'b1}, r);
        h_u.xfer({a, 1'b1}, r);
        h_u.xfer({d, 1'b1}, r);
        h_u.stop();
    endtask
    // Burst read; every byte but the last is acked
    task automatic rd(input logic [7:0] a, input int n);
        h_u.start();
        h_u.xfer({DEV, 1'b0, 1'b1}, r);
        h_u.xfer({a, 1'b1}, r);
        h_u.start();
        h_u.xfer({DEV, 1'b1, 1'b1}, r);
        for (int i = 0; i < n; i++) begin
            h_u.xfer({8'hFF, i == n - 1}, r);
            rd_v = r[8:1];
            -> got;
        end
        h_u.stop();
    endtask
    // One-cycle pulse
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk_i);
        s = 1'b0;
        @(negedge core_clk_i); // Gap so a repeated pulse never rises in the same step
    endtask
    // Each returned byte against the oldest note
    always @(got) begin
        ex = q.pop_front();
        `CHK("read byte", ex, rd_v)
    end
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk_i);
        num_errors++;
        results();
    end
    // Main sequence
    initial begin
        {rst_n_i, ipk, clean, otl, oth, cend, vlost, shrt, wdx, wsel, cool} = '0;
        evt = '0;
        sense = '{1'b1, 1'b1, 1'b0, 1'b1, CHG_FAST_CV, 3'b111, BAT_ABOVE_WEAK};
        repeat (20) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        `CHK("ctrl", {3'b111, 3'b100, 8'h47, 8'h00}, ctrl)
        q = '{8'h47, 8'h00, 8'h00, 8'h00, 8'hD3, 8'hE4, 8'h00, 8'h84, 8'h00};
        rd(ADDR_FUNC_ONE, 7);
        rd(ADDR_SHORT_CFG, 2);
        for (int c = 0; c < 8; c++) begin
            sense.charger_state_code = chg_state_type'(c);
            q.push_back({5'b11010, 3'(c)});
            rd(ADDR_STAT_ONE, 1);
        end
        sense.charger_state_code = CHG_FAST_CV; // Later notes expect the CV code
        wr(ADDR_FUNC_ONE, 8'h00);
        `CHK("ctrl", 3'b000, {ctrl.converter_enable, ctrl.trickle_path_enable, ctrl.termination_permit})
        wr(ADDR_FUNC_ONE, 8'h05);
        `CHK("ctrl", 3'b101, {ctrl.converter_enable, ctrl.trickle_path_enable, ctrl.termination_permit})
        repeat (4) begin
            m = 8'($random(seed));
            wr(ADDR_IRQ_EN, m);
            evt = chg_event_type'($random(seed));
            @(negedge core_clk_i);
            q = '{m & {1'b0, evt[4], 2'b00, evt[3:0]}, 8'h00};
            evt = '0;
            `CHK("pending", q[0], pend)
            rd(ADDR_IRQ_PEND, 1);
            rd(ADDR_IRQ_PEND, 1);
        end
        wr(ADDR_IRQ_EN, 8'hFF);
        pulse(otl);
        pulse(oth);
        pulse(cend);
        repeat (4) pulse(ipk);
        q = '{8'h90, 8'hDB, 8'hF4, 8'h07};
        rd(ADDR_IRQ_PEND, 4);
        wr(ADDR_FAULT, 8'h01);
        `CHK("run", 1'b0, ctrl.converter_enable)
        cool = 1'b1;
        @(negedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("run", 1'b1, ctrl.converter_enable)
        q = '{8'h06};
        rd(ADDR_FAULT, 1);
        pulse(vlost);
        pulse(clean);
        q = '{8'hD3, 8'hE4, 8'h00};
        rd(ADDR_STAT_ONE, 3);
        wr(ADDR_SHORT_CFG, 8'h06);
        `CHK("vsel", 3'b110, ctrl.short_voltage_sel)
        shrt = 1'b1;
        wdx = 1'b1;
        repeat (8100) @(negedge core_clk_i);
        q = '{8'h20, 8'hD3, 8'hE4, 8'h08};
        rd(ADDR_IRQ_PEND, 4);
        // Long watchdog period: no alarm at 2 s, alarm by 4 s
        wdx = 1'b0;
        wsel = 1'b1;
        @(negedge core_clk_i);
        wdx = 1'b1;
        repeat (8100) @(negedge core_clk_i);
        `CHK("wd", 1'b0, pend[IRQ_WD_BIT])
        repeat (8100) @(negedge core_clk_i);
        `CHK("wd", 1'b1, pend[IRQ_WD_BIT])
        `CHK("left", 0, q.size())
        results();
    end
endmodule
